/* File: verilog/reader_host_spi.sv */
// What this block does
// RL1 - Hold bit enters standby; radio sections off.
// RL2 - Registers survive standby and normal transitions.
// RL3 - Host waits about 12 ms after clearing hold before field on.
// RL4 - Host waits about 12 ms after enable rises before access.
// RL5 - Status shows oscillator stable; host polls it for one.
// RL6 - Field enable starts ramp-up at once; time and shape configurable.
// RL7 - Ramp-up end sets settled flag and analog-event interrupt.
// RL8 - Field disable ramps down, clears settled flag, raises interrupt.
// RL9 - Mode from enable pin, hold and field bits; ramp 12.5 us.
// RL10 - Serial port works only while chip select is low.
// RL11 - Input bits captured on falling serial clock edge.
// RL12 - Whole bytes, most significant bit first.
// RL13 - First byte: two op bits, six address bits.
// RL14 - Address increments after each data byte.
// RL15 - Output driven only while shifting read data.
// RL16 - Output pull-down while undriven if both bits set.
// RL17 - Host write: address byte, data bytes, select high.
// RL18 - Partial byte at select rise is discarded.
// RL19 - Writes to missing or read-only addresses change nothing.
// RL20 - Interrupt pin and host clock output provided.
// RL21 - Read bits shifted out on rising serial clock edge.
// RL22 - Unimplemented addresses read as zero.
// RL23 - Direct command acts at its byte's last falling edge.
// RL24 - Interrupt request is active high.
// RL25 - Select fall resets bit counter; next byte is address.
`timescale 1ns/10ps
module reader_host_spi (
    // Clock and reset
    input wire logic CLK_SYS_I,
    input wire logic RST_N_I,
    // Serial pins
    input wire logic CHIP_SELECT_N_I,
    input wire logic SCLK_I,
    input wire logic SDI_I,
    output logic SDO_O,
    output logic SDO_OE_O,
    output logic SDO_PD_EN_O,
    // Device pins and status
    input wire logic EN_I,
    input wire logic OSC_OK_I,
    output logic IRQ_O,
    output logic HOST_CLOCK_OUT_O,
    // Power and field control
    output reader_spi_pkg::power_mode_t POWER_MODE_O,
    output logic CORE_ACTIVE_O,
    output logic [7:0] FIELD_LEVEL_O,
    // Direct command strobe
    output reader_spi_pkg::cmd_t CMD_O
);
    import reader_spi_pkg::*;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [4:0] meta_q;
    logic [4:0] sync_q;
    logic cs_n;
    logic sclk;
    logic sdi;
    logic en;
    logic osc_ok;
    logic sclk_prev_q;
    logic cs_prev_q;
    logic sclk_fall;
    logic sclk_rise;
    logic cs_fall;

    // Two flops per pin; reset to idle levels so no false edge follows
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            meta_q <= 5'h10;
            sync_q <= 5'h10;
        end else begin
            meta_q <= {CHIP_SELECT_N_I, SCLK_I, SDI_I, EN_I, OSC_OK_I};
            sync_q <= meta_q;
        end
    end

    assign {cs_n, sclk, sdi, en, osc_ok} = sync_q;

    // Edge detectors on the synchronised serial clock and select
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            sclk_prev_q <= 1'b0;
            cs_prev_q <= 1'b1;
        end else begin
            sclk_prev_q <= sclk;
            cs_prev_q <= cs_n;
        end
    end

    assign sclk_fall = sclk_prev_q && !sclk && !cs_n; // RL10 RL11
    assign sclk_rise = !sclk_prev_q && sclk && !cs_n; // RL21
    assign cs_fall = cs_prev_q && !cs_n;

    // ----------------------------------------------------------------
    // Serial engine
    // ----------------------------------------------------------------
    spi_state_t state_q;
    logic [2:0] bit_cnt_q;
    logic [7:0] rx_q;
    logic [7:0] tx_q;
    logic [5:0] addr_q;
    logic sdo_q;
    logic [7:0] rx_byte;
    logic byte_done;
    logic wr_stb;
    logic rd_load;
    logic [5:0] rd_addr;
    logic [7:0] dev_ctrl_q;
    logic [7:0] misc1_q;
    logic [7:0] mod3_q;
    logic [7:0] status_byte;
    logic [7:0] irq_byte;
    logic irq_ana_q;
    logic irq_cmd_q;
    cmd_t cmd_q;

    assign rx_byte = {rx_q[6:0], sdi}; // RL12
    assign byte_done = sclk_fall && (bit_cnt_q == LAST_BIT);

    // Register read decode
    function automatic logic [7:0] reg_read(input logic [5:0] a, input logic [7:0] dc,
                                            input logic [7:0] m1, input logic [7:0] m3,
                                            input logic [7:0] st, input logic [7:0] iq);
        logic [7:0] r;
        r = BYTE_ZERO; // RL22
        if (a == ADDR_DEV_CTRL) begin
            r = dc;
        end else if (a == ADDR_MISC1) begin
            r = m1;
        end else if (a == ADDR_MOD_CTRL3) begin
            r = m3;
        end else if (a == ADDR_STATUS) begin
            r = st;
        end else if (a == ADDR_IRQ_STATUS) begin
            r = iq;
        end
        return r;
    endfunction

    // Bit counter and state; select fall restarts at address
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            state_q <= ST_IDLE;
            bit_cnt_q <= 3'h0;
        end else if (cs_n) begin
            state_q <= ST_IDLE; // RL10 RL18
            bit_cnt_q <= 3'h0;
        end else if (cs_fall) begin
            state_q <= ST_ADDR; // RL25
            bit_cnt_q <= 3'h0;
        end else if (sclk_fall) begin
            bit_cnt_q <= bit_cnt_q + 3'h1;
            if (byte_done && state_q == ST_ADDR) begin
                case (rx_byte[7:6]) // RL13
                    OP_WRITE: state_q <= ST_WRITE;
                    OP_READ: state_q <= ST_READ;
                    OP_CMD: state_q <= ST_CMD;
                    default: state_q <= ST_SKIP;
                endcase
            end
        end
    end

    // Input shifter, MSB first
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            rx_q <= BYTE_ZERO;
        end else if (cs_fall) begin
            rx_q <= BYTE_ZERO;
        end else if (sclk_fall) begin
            rx_q <= rx_byte; // RL11
        end
    end

    // Address pointer: loaded from the first byte, stepped per data byte
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            addr_q <= 6'h00;
        end else if (byte_done && state_q == ST_ADDR) begin
            addr_q <= rx_byte[5:0];
        end else if (byte_done && (state_q == ST_WRITE || state_q == ST_READ)) begin
            addr_q <= addr_q + 6'h01; // RL14
        end
    end

    // Writes commit on whole bytes only
    assign wr_stb = byte_done && state_q == ST_WRITE; // RL17 RL18

    // Read data fetched at each byte end, before the next rise
    assign rd_load = byte_done && (state_q == ST_READ ||
                                   (state_q == ST_ADDR && rx_byte[7:6] == OP_READ));
    assign rd_addr = (state_q == ST_ADDR) ? rx_byte[5:0] : addr_q + 6'h01;

    // Output shifter
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            tx_q <= BYTE_ZERO;
            sdo_q <= 1'b0;
        end else if (rd_load) begin
            tx_q <= reg_read(rd_addr, dev_ctrl_q, misc1_q, mod3_q, status_byte, irq_byte);
        end else if (sclk_rise && state_q == ST_READ) begin
            sdo_q <= tx_q[7]; // RL21 RL12
            tx_q <= {tx_q[6:0], 1'b0};
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    // Writable registers; only a serial write or reset alters them,
    // so mode changes leave them intact
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            dev_ctrl_q <= RST_DEV_CTRL;
            misc1_q <= RST_MISC1;
            mod3_q <= RST_MOD_CTRL3;
        end else if (wr_stb) begin // RL2
            if (addr_q == ADDR_DEV_CTRL) begin
                dev_ctrl_q <= rx_byte;
            end else if (addr_q == ADDR_MISC1) begin
                misc1_q <= rx_byte;
            end else if (addr_q == ADDR_MOD_CTRL3) begin
                mod3_q <= rx_byte;
            end
            // Status, interrupt status and unmapped addresses ignore writes RL19
        end
    end

    // Interrupt status: clear on read, a new event wins
    logic field_done;
    logic irq_clr;

    assign irq_clr = rd_load && rd_addr == ADDR_IRQ_STATUS;

    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            irq_ana_q <= 1'b0;
            irq_cmd_q <= 1'b0;
        end else begin
            if (field_done) begin
                irq_ana_q <= 1'b1; // RL7 RL8
            end else if (irq_clr) begin
                irq_ana_q <= 1'b0;
            end
            if (cmd_q.valid) begin
                irq_cmd_q <= 1'b1;
            end else if (irq_clr) begin
                irq_cmd_q <= 1'b0;
            end
        end
    end

    // Direct command strobe at the last falling edge of its byte
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            cmd_q <= '0;
        end else begin
            cmd_q.valid <= byte_done && state_q == ST_ADDR && rx_byte[7:6] == OP_CMD; // RL23
            if (byte_done && state_q == ST_ADDR) begin
                cmd_q.id <= rx_byte[5:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Power modes and field
    // ----------------------------------------------------------------
    logic stby;
    logic field_en;
    logic field_req;
    logic settled;
    ramp_cfg_t ramp_cfg;
    power_mode_t mode;

    assign stby = dev_ctrl_q[BIT_STBY];
    assign field_en = dev_ctrl_q[BIT_FIELD_EN];
    assign ramp_cfg.lin = mod3_q[BIT_LIN];
    assign ramp_cfg.trfon = mod3_q[BIT_TRFON_LO +: 2];

    // Mode decode from the enable pin and the two control bits
    always_comb begin
        if (!en) begin
            mode = PM_POWER_DOWN; // RL9
        end else if (stby) begin
            mode = PM_STANDBY; // RL1
        end else if (field_en) begin
            mode = PM_FIELD_ON;
        end else begin
            mode = PM_NORMAL;
        end
    end

    // The field only runs in field-on mode; leaving it ramps down
    assign field_req = (mode == PM_FIELD_ON); // RL6 RL8

    field_ramp u_ramp (
        .clk_i(CLK_SYS_I),
        .rst_n_i(RST_N_I),
        .field_req_i(field_req),
        .cfg_i(ramp_cfg),
        .level_o(FIELD_LEVEL_O),
        .settled_o(settled),
        .done_o(field_done)
    );

    assign status_byte = 8'((8'(osc_ok) << BIT_OSC_OK) | (8'(settled) << BIT_SETTLED)); // RL5
    assign irq_byte = 8'((8'(irq_ana_q) << BIT_IRQ_ANA) | (8'(irq_cmd_q) << BIT_IRQ_CMD));

    // Host clock divider; stopped in power down
    logic [3:0] div_q;
    logic host_clk_q;

    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            div_q <= 4'h0;
            host_clk_q <= 1'b0;
        end else if (!en) begin
            div_q <= 4'h0;
            host_clk_q <= 1'b0;
        end else if (div_q == HOST_CLK_HALF - 4'h1) begin
            div_q <= 4'h0;
            host_clk_q <= !host_clk_q; // RL20
        end else begin
            div_q <= div_q + 4'h1;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign SDO_O = sdo_q;
    assign SDO_OE_O = (state_q == ST_READ) && !cs_n; // RL15
    assign SDO_PD_EN_O = !SDO_OE_O && misc1_q[BIT_PD_A] && misc1_q[BIT_PD_B]; // RL16
    assign IRQ_O = irq_ana_q || irq_cmd_q; // RL24 RL20
    assign HOST_CLOCK_OUT_O = host_clk_q;
    assign POWER_MODE_O = mode;
    assign CORE_ACTIVE_O = (mode == PM_NORMAL) || (mode == PM_FIELD_ON); // RL1
    assign CMD_O = cmd_q;

endmodule

/* File: verilog/reader_spi_pkg.sv */
package reader_spi_pkg;

    // ----------------------------------------------------------------
    // Clock and timing
    // ----------------------------------------------------------------
    localparam int CLK_MHZ = 25;
    localparam int RAMP_NS_0 = 12500;
    localparam int RAMP_NS_1 = 25000;
    localparam int RAMP_NS_2 = 50000;
    localparam int RAMP_NS_3 = 100000;
    // Rounded up to whole cycles
    localparam int RAMP_CYC_0 = (RAMP_NS_0 * CLK_MHZ + 999) / 1000;
    localparam int RAMP_CYC_1 = (RAMP_NS_1 * CLK_MHZ + 999) / 1000;
    localparam int RAMP_CYC_2 = (RAMP_NS_2 * CLK_MHZ + 999) / 1000;
    localparam int RAMP_CYC_3 = (RAMP_NS_3 * CLK_MHZ + 999) / 1000;
    localparam int RAMP_CW = 12;
    localparam logic [7:0] LEVEL_MAX = 8'hff;
    localparam logic [7:0] LEVEL_MIN = 8'h00;

    // ----------------------------------------------------------------
    // Register map (six-bit addresses)
    // ----------------------------------------------------------------
    localparam logic [5:0] ADDR_DEV_CTRL = 6'h00;
    localparam logic [5:0] ADDR_MISC1 = 6'h0d;
    localparam logic [5:0] ADDR_MOD_CTRL3 = 6'h15;
    localparam logic [5:0] ADDR_STATUS = 6'h2a;
    localparam logic [5:0] ADDR_IRQ_STATUS = 6'h38;

    // Field positions
    localparam int BIT_STBY = 7;
    localparam int BIT_FIELD_EN = 6;
    localparam int BIT_PD_A = 1;
    localparam int BIT_PD_B = 0;
    localparam int BIT_LIN = 2;
    localparam int BIT_TRFON_LO = 0;
    localparam int BIT_OSC_OK = 0;
    localparam int BIT_SETTLED = 1;
    localparam int BIT_IRQ_ANA = 0;
    localparam int BIT_IRQ_CMD = 1;

    // Reset values
    localparam logic [7:0] RST_DEV_CTRL = 8'h00;
    localparam logic [7:0] RST_MISC1 = 8'h00;
    localparam logic [7:0] RST_MOD_CTRL3 = 8'h00;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    // Serial operation codes
    localparam logic [1:0] OP_WRITE = 2'b00;
    localparam logic [1:0] OP_READ = 2'b01;
    localparam logic [1:0] OP_CMD = 2'b10;
    localparam logic [2:0] LAST_BIT = 3'h7;

    // Host clock half period in cycles
    localparam logic [3:0] HOST_CLK_HALF = 4'h1;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_WRITE = 3'b011,
        ST_READ = 3'b010,
        ST_CMD = 3'b110,
        ST_SKIP = 3'b111
    } spi_state_t;

    typedef enum logic [1:0] {
        PM_POWER_DOWN = 2'b00,
        PM_STANDBY = 2'b01,
        PM_NORMAL = 2'b11,
        PM_FIELD_ON = 2'b10
    } power_mode_t;

    typedef struct packed {
        logic lin;
        logic [1:0] trfon;
    } ramp_cfg_t;

    typedef struct packed {
        logic valid;
        logic [5:0] id;
    } cmd_t;

endpackage

/* File: verilog/field_ramp.sv */
`timescale 1ns/10ps
module field_ramp (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Control
    input wire logic field_req_i,
    input wire reader_spi_pkg::ramp_cfg_t cfg_i,
    // Results
    output logic [7:0] level_o,
    output logic settled_o,
    output logic done_o
);
    import reader_spi_pkg::*;

    logic [7:0] lvl_q;
    logic [RAMP_CW-1:0] acc_q;
    logic settled_q;
    logic done_q;
    logic [RAMP_CW-1:0] span;
    logic [RAMP_CW-1:0] acc_sum;
    logic rising;
    logic falling;

    // Ramp span in cycles for the selected ramp time
    always_comb begin
        case (cfg_i.trfon)
            2'b00: span = RAMP_CW'(RAMP_CYC_0);
            2'b01: span = RAMP_CW'(RAMP_CYC_1);
            2'b10: span = RAMP_CW'(RAMP_CYC_2);
            default: span = RAMP_CW'(RAMP_CYC_3);
        endcase
    end

    assign rising = field_req_i && (lvl_q != LEVEL_MAX);
    assign falling = !field_req_i && (lvl_q != LEVEL_MIN);
    assign acc_sum = acc_q + RAMP_CW'(LEVEL_MAX);

    // 255 level steps spread over span cycles
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lvl_q <= LEVEL_MIN;
            acc_q <= '0;
        end else if (rising || falling) begin // RL6 RL8
            if (acc_sum >= span) begin
                acc_q <= acc_sum - span;
                lvl_q <= rising ? lvl_q + 8'h01 : lvl_q - 8'h01;
            end else begin
                acc_q <= acc_sum;
            end
        end else begin
            acc_q <= '0;
        end
    end

    // Settled flag and done pulse at ramp ends
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            settled_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (!settled_q && field_req_i && lvl_q == LEVEL_MAX) begin
                settled_q <= 1'b1; // RL7
                done_q <= 1'b1;
            end else if (settled_q && !field_req_i && lvl_q == LEVEL_MIN) begin
                settled_q <= 1'b0; // RL8
                done_q <= 1'b1;
            end
        end
    end

    // Linear or soft-start square law
    assign level_o = cfg_i.lin ? lvl_q : 8'((16'(lvl_q) * 16'(lvl_q)) >> 8);
    assign settled_o = settled_q;
    assign done_o = done_q;

endmodule

/* File: bench/reader_host_spi_properties.sv */
`timescale 1ns/10ps
module reader_host_spi_props (
    // Clock and reset
    input wire logic CLK_SYS_I,
    input wire logic RST_N_I,
    // Pins watched
    input wire logic CHIP_SELECT_N_I,
    input wire logic EN_I,
    input wire logic SDO_OE_O,
    input wire logic SDO_PD_EN_O,
    input wire logic IRQ_O,
    input wire logic HOST_CLOCK_OUT_O,
    input wire reader_spi_pkg::power_mode_t POWER_MODE_O,
    input wire logic CORE_ACTIVE_O,
    input wire logic [7:0] FIELD_LEVEL_O,
    input wire reader_spi_pkg::cmd_t CMD_O
);
    import reader_spi_pkg::*;

    default clocking cb @(posedge CLK_SYS_I);
    endclocking
    default disable iff (!RST_N_I);

    // ------------------------------------------------------------
    // Sequences
    // ------------------------------------------------------------
    // Enable levels that pass the sync
    sequence s_en_off;
        !EN_I [*4];
    endsequence
    sequence s_en_on;
        EN_I [*6];
    endsequence
    sequence s_field_up;
        $rose(POWER_MODE_O == PM_FIELD_ON);
    endsequence
    sequence s_cmd_tail;
        ##1 !CMD_O.valid;
    endsequence

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    property p_oe_cs;
        SDO_OE_O |-> !$past(CHIP_SELECT_N_I, 4);
    endproperty
    property p_pd_excl;
        SDO_PD_EN_O |-> !SDO_OE_O;
    endproperty
    property p_core;
        CORE_ACTIVE_O == (POWER_MODE_O inside {PM_NORMAL, PM_FIELD_ON});
    endproperty
    property p_pdown;
        s_en_off |-> POWER_MODE_O == PM_POWER_DOWN;
    endproperty
    property p_hclk_off;
        s_en_off |-> !HOST_CLOCK_OUT_O;
    endproperty
    property p_hclk_run;
        s_en_on |-> ##[0:3] HOST_CLOCK_OUT_O != $past(HOST_CLOCK_OUT_O);
    endproperty
    // Loose: square law stays zero at first
    property p_ramp;
        s_field_up |-> ##[1:300] FIELD_LEVEL_O != LEVEL_MIN;
    endproperty
    property p_cmd_pulse;
        CMD_O.valid |-> s_cmd_tail;
    endproperty
    property p_cmd_irq;
        CMD_O.valid |-> ##[0:3] IRQ_O;
    endproperty

    a_oe_cs: assert property (p_oe_cs) else $error("SDO driven with select high");
    a_pd_excl: assert property (p_pd_excl) else $error("pull-down while driving");
    a_core: assert property (p_core) else $error("core activity mismatch");
    a_pdown: assert property (p_pdown) else $error("no power down");
    a_hclk_off: assert property (p_hclk_off) else $error("host clock runs");
    a_hclk_run: assert property (p_hclk_run) else $error("host clock stuck");
    a_ramp: assert property (p_ramp) else $error("ramp did not start");
    a_cmd_pulse: assert property (p_cmd_pulse) else $error("command strobe long");
    a_cmd_irq: assert property (p_cmd_irq) else $error("no command interrupt");
endmodule

bind reader_host_spi reader_host_spi_props u_props (
    .CLK_SYS_I(CLK_SYS_I),
    .RST_N_I(RST_N_I),
    .CHIP_SELECT_N_I(CHIP_SELECT_N_I),
    .EN_I(EN_I),
    .SDO_OE_O(SDO_OE_O),
    .SDO_PD_EN_O(SDO_PD_EN_O),
    .IRQ_O(IRQ_O),
    .HOST_CLOCK_OUT_O(HOST_CLOCK_OUT_O),
    .POWER_MODE_O(POWER_MODE_O),
    .CORE_ACTIVE_O(CORE_ACTIVE_O),
    .FIELD_LEVEL_O(FIELD_LEVEL_O),
    .CMD_O(CMD_O)
);

/* File: bench/spi_host_model.sv */
`timescale 1ns/10ps
module spi_host_model (
    // Serial pins toward the device
    output logic cs_n_o,
    output logic sclk_o,
    output logic sdi_o,
    input wire logic sdo_i,
    input wire logic sdo_oe_i,
    input wire logic sdo_pd_en_i
);
    logic last_q;
    logic line_w;

    // Released line: pull-down, else inverted last bit
    always @(sdo_i or sdo_oe_i) if (sdo_oe_i) last_q = sdo_i;
    assign line_w = sdo_oe_i ? sdo_i : (sdo_pd_en_i ? 1'b0 : ~last_q);

    // Idle: select high, clock parked low
    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        sdi_o = 1'b0;
        last_q = 1'b0;
    end

    // Offset keeps link off the system clock phase
    task automatic open_frame();
        #13;
        cs_n_o = 1'b0;
        #320;
    endtask

    // Gap lets the device see the frame end
    task automatic close_frame();
        #160;
        cs_n_o = 1'b1;
        #640;
    endtask

    // Change on rise, sample on fall, MSB first
    task automatic shift(input logic [7:0] b, input int n, output logic [7:0] r);
        r = 8'h00;
        for (int i = 7; i > 7 - n; i--) begin
            sclk_o = 1'b1;
            sdi_o = b[i];
            #160;
            sclk_o = 1'b0;
            r = {r[6:0], line_w};
            #160;
        end
    endtask

    // Edges with select high
    task automatic stray();
        for (int i = 0; i < 8; i++) begin
            sclk_o = 1'b1;
            sdi_o = ~sdi_o;
            #160;
            sclk_o = 1'b0;
            #160;
        end
    endtask
endmodule

/* File: bench/reader_host_spi_tb.sv */
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin fails++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end
module reader_host_spi_tb;
    import reader_spi_pkg::*;

    logic clk, rst_n, en, osc_ok, cs_n, sclk, sdi, sdo, sdo_oe, sdo_pd, irq, hclk, core;
    power_mode_t mode;
    logic [7:0] level, rv;
    cmd_t cmd;
    logic [5:0] cmd_id;
    logic [5:0] ids [2] = '{6'h05, 6'h3a};
    int fails, checked, cycles, cmd_cnt, n;

    reader_host_spi uut (.CLK_SYS_I(clk), .RST_N_I(rst_n), .CHIP_SELECT_N_I(cs_n),
        .SCLK_I(sclk), .SDI_I(sdi), .SDO_O(sdo), .SDO_OE_O(sdo_oe), .SDO_PD_EN_O(sdo_pd),
        .EN_I(en), .OSC_OK_I(osc_ok), .IRQ_O(irq), .HOST_CLOCK_OUT_O(hclk),
        .POWER_MODE_O(mode), .CORE_ACTIVE_O(core), .FIELD_LEVEL_O(level), .CMD_O(cmd));
    spi_host_model host (.cs_n_o(cs_n), .sclk_o(sclk), .sdi_o(sdi), .sdo_i(sdo),
        .sdo_oe_i(sdo_oe), .sdo_pd_en_i(sdo_pd));

    // ------------------------------------------------------------
    // Clock, watchdog and command monitor
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Run takes about 5.9k cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            fails++;
            stop_test();
        end
    end
    always @(posedge clk) if (cmd.valid === 1'b1) begin
        cmd_cnt++;
        cmd_id = cmd.id;
    end

    // ------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        logic [7:0] r;
        host.open_frame();
        host.shift({OP_WRITE, a}, 8, r);
        host.shift(d, 8, r);
        host.close_frame();
    endtask
    task automatic chk_rd(input string nm, input logic [5:0] a, input logic [7:0] e);
        logic [7:0] d;
        host.open_frame();
        host.shift({OP_READ, a}, 8, d);
        host.shift(8'h00, 8, d);
        host.close_frame();
        `CHK(nm, e, d)
    endtask
    // Bounded wait
    task automatic wait_irq(output int c);
        c = 0;
        while (irq !== 1'b1 && c < 3000) begin
            @(posedge clk);
            c++;
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        en = 1'b0;
        osc_ok = 1'b0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge clk);
        `CHK("mode off", PM_POWER_DOWN, mode)
        en <= 1'b1;
        // Short settle: no analog bias here
        repeat (20) @(posedge clk);
        `CHK("mode normal", PM_NORMAL, mode)
        chk_rd("osc low", ADDR_STATUS, 8'h00);
        @(posedge clk) osc_ok <= 1'b1;
        chk_rd("osc ok", ADDR_STATUS, 8'h01);
        chk_rd("ctrl rst", ADDR_DEV_CTRL, RST_DEV_CTRL);
        chk_rd("mod rst", ADDR_MOD_CTRL3, RST_MOD_CTRL3);
        chk_rd("unmapped", 6'h3f, BYTE_ZERO);
        // Burst from a register into an unmapped one
        host.open_frame();
        host.shift({OP_WRITE, ADDR_MISC1}, 8, rv);
        host.shift(8'h03, 8, rv);
        host.shift(8'hff, 8, rv);
        host.close_frame();
        `CHK("pulldown", 1'b1, sdo_pd)
        host.open_frame();
        host.shift({OP_READ, ADDR_MISC1}, 8, rv);
        host.shift(8'h00, 8, rv);
        `CHK("burst rd0", 8'h03, rv)
        host.shift(8'h00, 8, rv);
        `CHK("burst rd1", BYTE_ZERO, rv)
        host.close_frame();
        wr(ADDR_STATUS, 8'hfc);
        wr(ADDR_IRQ_STATUS, 8'hff);
        chk_rd("status ro", ADDR_STATUS, 8'h01);
        chk_rd("irq ro", ADDR_IRQ_STATUS, 8'h00);
        // Partial bytes, then stray clocks
        host.open_frame();
        host.shift({OP_WRITE, ADDR_MOD_CTRL3}, 8, rv);
        host.shift(8'hff, 5, rv);
        host.close_frame();
        chk_rd("partial", ADDR_MOD_CTRL3, 8'h00);
        host.open_frame();
        host.shift(8'hff, 3, rv);
        host.close_frame();
        host.stray();
        chk_rd("reframe", ADDR_MISC1, 8'h03);
        host.open_frame();
        host.shift({2'b11, ADDR_MISC1}, 8, rv);
        host.shift(8'h00, 8, rv);
        host.close_frame();
        chk_rd("reserved", ADDR_MISC1, 8'h03);
        `CHK("no cmd", 0, cmd_cnt)
        foreach (ids[i]) begin
            host.open_frame();
            host.shift({OP_CMD, ids[i]}, 8, rv);
            host.close_frame();
            `CHK("cmd count", i + 1, cmd_cnt)
            `CHK("cmd id", ids[i], cmd_id)
            `CHK("cmd irq", 1'b1, irq)
            chk_rd("irq cmd", ADDR_IRQ_STATUS, 8'h02);
            `CHK("irq clr", 1'b0, irq)
        end
        wr(ADDR_MISC1, 8'h01);
        `CHK("pd off", 1'b0, sdo_pd)
        wr(ADDR_DEV_CTRL, 8'h80);
        `CHK("mode stby", PM_STANDBY, mode)
        `CHK("core off", 1'b0, core)
        chk_rd("keep stby", ADDR_MISC1, 8'h01);
        wr(ADDR_DEV_CTRL, 8'h00);
        chk_rd("keep norm", ADDR_MISC1, 8'h01);
        // Linear, shortest ramp; span from write return
        wr(ADDR_MOD_CTRL3, 8'h04);
        wr(ADDR_DEV_CTRL, 8'h40);
        `CHK("mode field", PM_FIELD_ON, mode)
        wait_irq(n);
        `CHK("ramp up", 1'b1, (n >= RAMP_CYC_0 - 30 && n <= RAMP_CYC_0 - 8))
        `CHK("level top", LEVEL_MAX, level)
        chk_rd("settled", ADDR_STATUS, 8'h03);
        chk_rd("irq up", ADDR_IRQ_STATUS, 8'h01);
        wr(ADDR_DEV_CTRL, 8'h00);
        wait_irq(n);
        `CHK("ramp down", 1'b1, (n >= RAMP_CYC_0 - 30 && n <= RAMP_CYC_0 - 8))
        `CHK("level low", LEVEL_MIN, level)
        chk_rd("unsettled", ADDR_STATUS, 8'h01);
        chk_rd("irq down", ADDR_IRQ_STATUS, 8'h01);
        @(posedge clk) en <= 1'b0;
        repeat (6) @(posedge clk);
        `CHK("mode pd", PM_POWER_DOWN, mode)
        `CHK("hclk off", 1'b0, hclk)
        en <= 1'b1;
        repeat (6) @(posedge clk);
        chk_rd("keep pd", ADDR_MISC1, 8'h01);
        stop_test();
    end
endmodule
